// file: design/ifr_regs.svh
`ifndef IFR_REGS_SVH
`define IFR_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IFR_OFS_SECOND 8'h00
`define IFR_OFS_THIRD  8'h04
`define IFR_OFS_FOURTH 8'h08

// ----------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------
`define IFR_MASK_SECOND 16'hdfff
`define IFR_MASK_THIRD  16'ha7ff
`define IFR_MASK_FOURTH 16'h00f7
`define IFR_RST_FLAGS   16'h0000

// ----------------------------------------
// decode and lane constants
// ----------------------------------------
`define IFR_OFS_W      8
`define IFR_IDX_W      2
`define IFR_IDX_SECOND 2'h0
`define IFR_IDX_THIRD  2'h1
`define IFR_IDX_FOURTH 2'h2
`define IFR_IDX_NONE   2'h3
`define IFR_NUM_REGS   3
`define IFR_LANE_LO    0
`define IFR_LANE_HI    1
`define IFR_RD_PAD     16'h0000
`define IFR_RD_NONE    32'h0000_0000

`endif

// file: design/ifr_pkg.sv
package ifr_pkg;

	// ----------------------------------------
	// classic wishbone request from the master
	// ----------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} ifr_wb_req_t;

	// ----------------------------------------
	// flag layouts, msb first
	// ----------------------------------------
	typedef struct packed {
		logic timer_six_pending;
		logic dma_ch_four_done_pending;
		logic rsvd_13;
		logic out_compare_eight_pending;
		logic out_compare_seven_pending;
		logic out_compare_six_pending;
		logic out_compare_five_pending;
		logic in_capture_six_pending;
		logic in_capture_five_pending;
		logic in_capture_four_pending;
		logic in_capture_three_pending;
		logic dma_ch_three_done_pending;
		logic can_one_event_pending;
		logic can_one_rx_ready_pending;
		logic spi_two_event_pending;
		logic spi_two_error_pending;
	} ifr_second_t;

	typedef struct packed {
		logic       pwm_fault_a_pending;
		logic       rsvd_14;
		logic       dma_ch_five_done_pending;
		logic [1:0] rsvd_12_11;
		logic       quad_encoder_event_pending;
		logic       pwm_error_pending;
		logic       can_two_event_pending;
		logic       can_two_rx_ready_pending;
		logic       ext_irq_four_pending;
		logic       ext_irq_three_pending;
		logic       timer_nine_pending;
		logic       timer_eight_pending;
		logic       i2c_two_master_pending;
		logic       i2c_two_slave_pending;
		logic       timer_seven_pending;
	} ifr_third_t;

	typedef struct packed {
		logic [7:0] rsvd_15_8;
		logic       can_two_tx_request_pending;
		logic       can_one_tx_request_pending;
		logic       dma_ch_seven_done_pending;
		logic       dma_ch_six_done_pending;
		logic       rsvd_3;
		logic       uart_two_error_pending;
		logic       uart_one_error_pending;
		logic       pwm_fault_b_pending;
	} ifr_fourth_t;

endpackage : ifr_pkg

// file: design/ifr_flags.sv
`timescale 1ns/10ps
`include "ifr_regs.svh"


module ifr_flags
	import ifr_pkg::*;
#(
	parameter int ADR_W = 8
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire ifr_wb_req_t wb_req,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	input  wire ifr_second_t ev_second,
	input  wire ifr_third_t  ev_third,
	input  wire ifr_fourth_t ev_fourth,
	output ifr_second_t      irq_flags_second,
	output ifr_third_t       irq_flags_third,
	output ifr_fourth_t      irq_flags_fourth
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (ADR_W < `IFR_OFS_W || ADR_W > 32) begin : g_bad_adr_w
		$error("ADR_W must lie between 8 and 32");
	end

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic [`IFR_IDX_W-1:0] idx;
	logic                  upper_zero;
	logic                  req_take;
	logic                  wr_fire;
	logic                  ack_q;
	logic [31:0]           dat_q;

	// alias decode: address bits 8 to ADR_W-1 must be zero, no mirroring below ADR_W
	always_comb begin
		upper_zero = 1'b1;
		for (int b = `IFR_OFS_W; b < ADR_W; b++) begin
			if (wb_req.adr[b]) begin
				upper_zero = 1'b0;
			end
		end
	end

	always_comb begin
		if (!upper_zero) begin
			idx = `IFR_IDX_NONE;
		end else if (wb_req.adr[`IFR_OFS_W-1:0] == `IFR_OFS_SECOND) begin
			idx = `IFR_IDX_SECOND;
		end else if (wb_req.adr[`IFR_OFS_W-1:0] == `IFR_OFS_THIRD) begin
			idx = `IFR_IDX_THIRD;
		end else if (wb_req.adr[`IFR_OFS_W-1:0] == `IFR_OFS_FOURTH) begin
			idx = `IFR_IDX_FOURTH;
		end else begin
			idx = `IFR_IDX_NONE;
		end
	end

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// ack one cycle after the request; never two acks back to back
	assign req_take = wb_req.cyc && wb_req.stb && !ack_q;
	// write lands on the edge where the master samples ack
	assign wr_fire  = wb_req.cyc && wb_req.stb && wb_req.we && ack_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req_take;
		end
	end

	// ----------------------------------------
	// flag storage
	// ----------------------------------------
	logic [15:0] flags_q [`IFR_NUM_REGS];
	logic [15:0] ev_vec  [`IFR_NUM_REGS];
	logic [15:0] mask    [`IFR_NUM_REGS];

	assign ev_vec[0] = ev_second;
	assign ev_vec[1] = ev_third;
	assign ev_vec[2] = ev_fourth;
	// masks keep every source bit; holes never store
	assign mask[0]   = `IFR_MASK_SECOND;
	assign mask[1]   = `IFR_MASK_THIRD;
	assign mask[2]   = `IFR_MASK_FOURTH;

	for (genvar i = 0; i < `IFR_NUM_REGS; i++) begin : g_reg
		logic        hit;
		logic [15:0] sw_val;

		assign hit = wr_fire && (idx == `IFR_IDX_W'(i));

		// byte lanes the master did not select keep their flags
		always_comb begin
			sw_val = flags_q[i];
			if (hit && wb_req.sel[`IFR_LANE_LO]) begin
				sw_val[7:0] = wb_req.dat[7:0];
			end
			if (hit && wb_req.sel[`IFR_LANE_HI]) begin
				sw_val[15:8] = wb_req.dat[15:8];
			end
		end

		// event ors in after the write so a set beats a same-cycle clear
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				flags_q[i] <= `IFR_RST_FLAGS;
			end else begin
				flags_q[i] <= (sw_val | ev_vec[i]) & mask[i];
			end
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// captured at request time; unmapped reads answer zero, writes drop
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dat_q <= `IFR_RD_NONE;
		end else if (req_take && !wb_req.we) begin
			if (idx == `IFR_IDX_NONE) begin
				dat_q <= `IFR_RD_NONE;
			end else begin
				dat_q <= {`IFR_RD_PAD, flags_q[idx]};
			end
		end
	end

	assign wb_ack_o         = ack_q;
	assign wb_dat_o         = dat_q;
	assign irq_flags_second = flags_q[0];
	assign irq_flags_third  = flags_q[1];
	assign irq_flags_fourth = flags_q[2];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_take;
		wb_req.cyc && wb_req.stb && !ack_q;
	endsequence

	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	sequence s_clear_lo_second;
		wr_fire && idx == `IFR_IDX_SECOND && wb_req.sel[0] && !wb_req.dat[0]
			&& !ev_second.spi_two_error_pending;
	endsequence

	a_ack_one_pulse: assert property (s_take |=> s_ack_pulse)
		else $error("ack not a single pulse after request");

	a_reset_clears: assert property (disable iff (1'b0)
		sys_rst |=> (irq_flags_second == 16'h0000 && irq_flags_third == 16'h0000
			&& irq_flags_fourth == 16'h0000))
		else $error("flags not zero after reset");

	a_hole_second: assert property (!irq_flags_second.rsvd_13)
		else $error("second register bit 13 not zero");

	a_hole_third: assert property (
		!irq_flags_third.rsvd_14 && irq_flags_third.rsvd_12_11 == 2'h0)
		else $error("third register hole not zero");

	a_hole_fourth_hi: assert property (irq_flags_fourth.rsvd_15_8 == 8'h00)
		else $error("fourth register upper byte not zero");

	a_hole_fourth_b3: assert property (!irq_flags_fourth.rsvd_3)
		else $error("fourth register bit 3 not zero");

	a_second_map_hi: assert property (
		ev_second.timer_six_pending |=> irq_flags_second[15])
		else $error("timer six event not at bit 15");

	a_second_map_mid: assert property (
		ev_second.dma_ch_three_done_pending |=> irq_flags_second[4])
		else $error("dma three event not at bit 4");

	a_second_map_lo: assert property (
		ev_second.can_one_event_pending |=> irq_flags_second[3])
		else $error("can one event not at bit 3");

	a_third_map_hi: assert property (
		ev_third.quad_encoder_event_pending |=> irq_flags_third[10])
		else $error("encoder event not at bit 10");

	a_third_map_lo: assert property (
		ev_third.timer_seven_pending |=> irq_flags_third[0])
		else $error("timer seven event not at bit 0");

	a_fourth_map: assert property (
		ev_fourth.uart_two_error_pending |=> irq_flags_fourth[2])
		else $error("uart two error not at bit 2");

	a_flag_sticky: assert property (
		irq_flags_second[0] && !(wr_fire && idx == `IFR_IDX_SECOND)
		|=> irq_flags_second[0])
		else $error("flag dropped without software write");

	a_sw_clear: assert property (s_clear_lo_second |=> !irq_flags_second[0])
		else $error("software write of zero did not clear");

	a_read_value: assert property (
		s_take ##0 (!wb_req.we && idx == `IFR_IDX_THIRD)
		|=> wb_ack_o && wb_dat_o == {16'h0000, $past(flags_q[1])})
		else $error("read data does not match flags");

	a_set_wins: assert property (
		wr_fire && idx == `IFR_IDX_SECOND && wb_req.sel[0] && !wb_req.dat[0]
		&& ev_second.spi_two_error_pending |=> irq_flags_second[0])
		else $error("clearing write beat a same-cycle event");

	a_second_map_dma: assert property (
		(ev_second.dma_ch_four_done_pending |=> irq_flags_second[14])
		and (ev_second.out_compare_seven_pending |=> irq_flags_second[11])
		and (ev_second.out_compare_six_pending |=> irq_flags_second[10]))
		else $error("dma four or compare event off its bit");

	a_second_map_oc: assert property (
		(ev_second.out_compare_eight_pending |=> irq_flags_second[12])
		and (ev_second.out_compare_five_pending |=> irq_flags_second[9])
		and (ev_second.in_capture_six_pending |=> irq_flags_second[8]))
		else $error("compare or capture six event off its bit");

	a_second_map_cap: assert property (
		(ev_second.in_capture_five_pending |=> irq_flags_second[7])
		and (ev_second.in_capture_four_pending |=> irq_flags_second[6])
		and (ev_second.in_capture_three_pending |=> irq_flags_second[5]))
		else $error("capture event off its bit");

	a_second_map_spi: assert property (
		(ev_second.can_one_rx_ready_pending |=> irq_flags_second[2])
		and (ev_second.spi_two_event_pending |=> irq_flags_second[1]))
		else $error("can one rx or spi event off its bit");

	a_third_map_fault: assert property (
		(ev_third.pwm_fault_a_pending |=> irq_flags_third[15])
		and (ev_third.dma_ch_five_done_pending |=> irq_flags_third[13])
		and (ev_third.pwm_error_pending |=> irq_flags_third[9])
		and (ev_third.can_two_event_pending |=> irq_flags_third[8]))
		else $error("fault, dma five, pwm or can two event off its bit");

	a_third_map_ext: assert property (
		(ev_third.can_two_rx_ready_pending |=> irq_flags_third[7])
		and (ev_third.ext_irq_four_pending |=> irq_flags_third[6])
		and (ev_third.ext_irq_three_pending |=> irq_flags_third[5])
		and (ev_third.timer_nine_pending |=> irq_flags_third[4])
		and (ev_third.timer_eight_pending |=> irq_flags_third[3]))
		else $error("can two rx, external or timer event off its bit");

	a_third_map_i2c: assert property (
		(ev_third.i2c_two_master_pending |=> irq_flags_third[2])
		and (ev_third.i2c_two_slave_pending |=> irq_flags_third[1]))
		else $error("i2c event off its bit");

	a_fourth_map_can: assert property (
		(ev_fourth.can_two_tx_request_pending |=> irq_flags_fourth[7])
		and (ev_fourth.can_one_tx_request_pending |=> irq_flags_fourth[6])
		and (ev_fourth.dma_ch_seven_done_pending |=> irq_flags_fourth[5])
		and (ev_fourth.dma_ch_six_done_pending |=> irq_flags_fourth[4]))
		else $error("can tx or dma event off its bit");

	a_fourth_map_lo: assert property (
		(ev_fourth.uart_one_error_pending |=> irq_flags_fourth[1])
		and (ev_fourth.pwm_fault_b_pending |=> irq_flags_fourth[0]))
		else $error("uart one error or fault b off its bit");

	a_no_stray_set: assert property (
		!irq_flags_third[0] && !ev_third.timer_seven_pending
		&& !(wr_fire && idx == `IFR_IDX_THIRD) |=> !irq_flags_third[0])
		else $error("flag rose with no event and no write");

	a_read_none: assert property (
		s_take ##0 (!wb_req.we && idx == `IFR_IDX_NONE) |=> wb_dat_o == `IFR_RD_NONE)
		else $error("unmapped read did not answer zero");

	a_reset_outputs: assert property (disable iff (1'b0)
		sys_rst |=> !wb_ack_o && wb_dat_o == `IFR_RD_NONE)
		else $error("bus outputs not idle after reset");

endmodule : ifr_flags

// file: tb/ifr_src_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// peripheral event sources: one-cycle pulses, idle low
// ----------------------------------------
module ifr_src_model
	import ifr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        fire,
	input  wire logic [47:0] pat,
	output ifr_second_t      ev_second,
	output ifr_third_t       ev_third,
	output ifr_fourth_t      ev_fourth
);
	// reserved positions are driven too, the block must ignore them
	always_ff @(posedge mclk) begin
		if (sys_rst || !fire) begin
			{ev_fourth, ev_third, ev_second} <= 48'h0;
		end else begin
			{ev_fourth, ev_third, ev_second} <= pat;
		end
	end
endmodule : ifr_src_model

// file: tb/tb_interrupt_flag_status_regs_2_to_4.sv
`timescale 1ns/10ps
`include "ifr_regs.svh"

module tb_interrupt_flag_status_regs_2_to_4;
	import ifr_pkg::*;
	logic        mclk, sys_rst, fire, wb_ack_o;
	ifr_wb_req_t wb_req;
	logic [31:0] wb_dat_o;
	logic [47:0] pat, flags_all;
	ifr_second_t ev_second, irq_flags_second;
	ifr_third_t  ev_third, irq_flags_third;
	ifr_fourth_t ev_fourth, irq_flags_fourth;
	logic [15:0] expect_flags [3];
	logic [15:0] mask [3];
	logic [7:0]  ofs [3];
	int          err_total, samples_checked, cyc_cnt, seed, r;

	assign flags_all = {irq_flags_fourth, irq_flags_third, irq_flags_second};

	ifr_flags i_dut (.mclk(mclk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .ev_second(ev_second), .ev_third(ev_third),
		.ev_fourth(ev_fourth), .irq_flags_second(irq_flags_second),
		.irq_flags_third(irq_flags_third), .irq_flags_fourth(irq_flags_fourth));

	ifr_src_model i_src (.mclk(mclk), .sys_rst(sys_rst), .fire(fire), .pat(pat),
		.ev_second(ev_second), .ev_third(ev_third), .ev_fourth(ev_fourth));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_total++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	// a hung handshake ends here rather than running forever
	always @(posedge mclk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			conclude();
		end
	end

	// ----------------------------------------
	// bus and event tasks
	// ----------------------------------------
	task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [15:0] dat, output logic [31:0] data);
		@(posedge mclk);
		wb_req <= '{1'b1, 1'b1, we, sel, {24'h0, adr}, {16'h0, dat}};
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		data = wb_dat_o;
		wb_req.cyc <= 1'b0;
		wb_req.stb <= 1'b0;
	endtask : bus

	// unselected lanes keep their flags, holes stay zero
	function automatic logic [15:0] after_wr(input logic [15:0] old, input logic [3:0] sel,
		input logic [15:0] dat, input logic [15:0] m);
		logic [15:0] lm;
		lm = {{8{sel[1]}}, {8{sel[0]}}};
		return (old & ~lm) | (dat & lm & m);
	endfunction : after_wr

	task automatic rd_chk(input int i);
		logic [31:0] d;
		bus(1'b0, ofs[i], 4'h3, 16'h0, d);
		check(d, {16'h0, expect_flags[i]});
		check({16'h0, flags_all[16*i +: 16]}, {16'h0, expect_flags[i]});
	endtask : rd_chk

	task automatic wr(input int i, input logic [3:0] sel, input logic [15:0] dat);
		logic [31:0] d;
		bus(1'b1, ofs[i], sel, dat, d);
		expect_flags[i] = after_wr(expect_flags[i], sel, dat, mask[i]);
	endtask : wr

	task automatic pulse(input logic [47:0] p);
		@(posedge mclk);
		fire <= 1'b1;
		pat <= p;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 3; i++) expect_flags[i] |= p[16*i +: 16] & mask[i];
	endtask : pulse

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		seed = 61816;
		sys_rst = 1'b1;
		fire = 1'b0;
		pat = 48'h0;
		wb_req = '0;
		err_total = 0;
		samples_checked = 0;
		cyc_cnt = 0;
		expect_flags = '{default: 16'h0};
		mask = '{`IFR_MASK_SECOND, `IFR_MASK_THIRD, `IFR_MASK_FOURTH};
		ofs = '{`IFR_OFS_SECOND, `IFR_OFS_THIRD, `IFR_OFS_FOURTH};
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 3; i++) rd_chk(i);
		for (int i = 0; i < 3; i++) begin
			wr(i, 4'h3, 16'hffff);
			rd_chk(i);
			wr(i, 4'h3, 16'h0);
			rd_chk(i);
		end
		// walking event shows each source lands on its own bit only
		for (int b = 0; b < 48; b++) begin
			pulse(48'h1 << b);
			rd_chk(b / 16);
			wr(b / 16, 4'h3, 16'h0);
			rd_chk(b / 16);
		end
		// unmapped word: answered with zero, write must not land anywhere
		bus(1'b1, 8'h0c, 4'hf, 16'hffff, d);
		bus(1'b0, 8'h0c, 4'h0, 16'h0, d);
		check(d, 32'h0);
		for (int i = 0; i < 3; i++) rd_chk(i);
		// event on the edge of a clearing write: the event wins
		wr(0, 4'h3, 16'hffff);
		fork
			wr(0, 4'h3, 16'h0);
			pulse(48'h1);
		join
		rd_chk(0);
		// reset in mid-run wipes every stored flag
		for (int i = 0; i < 3; i++) wr(i, 4'h3, 16'hffff);
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		expect_flags = '{default: 16'h0};
		for (int i = 0; i < 3; i++) rd_chk(i);
		repeat (60) begin
			r = $random(seed);
			if (r[31]) pulse({16'($random(seed)), $random(seed)});
			else wr($unsigned(r) % 3, r[7:4], r[23:8]);
			rd_chk($unsigned(r) % 3);
		end
		conclude();
	end
endmodule : tb_interrupt_flag_status_regs_2_to_4
